// File: serial_request_and_cyclic_report_bench.sv
`timescale 1ns/1ps
module serial_request_and_cyclic_report_bench;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic rxd, txd_out, layout_sel_in, resp_valid_in, resp_ready_out;
  logic rx_valid_out, rx_error_out, mode, got, got_ok, par_en;
  logic err_seen, took;
  logic [6:0] dev_addr_in, dev_addr_out;
  logic [2:0] baud_sel_in;
  logic [3:0] frame_sel_in, nbits;
  logic [9:0] cycle_time_in;
  logic [4:0] reg_sel_in;
  logic [19:0] reg_val [20];
  logic [19:0] basic_value_in;
  logic reg_neg [20];
  logic [7:0] resp_char_in, rx_char_out, got_char, rx_seen;
  logic [8:0] exp_q [$];
  logic [6:0] addr_tab [6] = '{7'h00, 7'h0a, 7'h0b, 7'h2d, 7'h63, 7'h64};
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #5 clk_sys_in = ~clk_sys_in;
  srcr_serial_link #(.SILENCE_CYC(5000), .TICK_CYC(50)) uut (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .rxd_in(rxd),
    .txd_out(txd_out),
    .dev_addr_in(dev_addr_in),
    .baud_sel_in(baud_sel_in),
    .frame_sel_in(frame_sel_in),
    .layout_sel_in(layout_sel_in),
    .cycle_time_in(cycle_time_in),
    .reg_sel_in(reg_sel_in),
    .reg_value_in(reg_val),
    .basic_value_in(basic_value_in),
    .reg_neg_in(reg_neg),
    .resp_valid_in(resp_valid_in),
    .resp_char_in(resp_char_in),
    .resp_ready_out(resp_ready_out),
    .rx_char_out(rx_char_out),
    .rx_valid_out(rx_valid_out),
    .rx_error_out(rx_error_out),
    .request_response_mode_out(mode),
    .dev_addr_out(dev_addr_out)
  );
  // Bit period of 38400 baud at 100 MHz
  srcr_host_model host (
    .clk_sys_in(clk_sys_in),
    .txd_in(txd_out),
    .rxd_out(rxd),
    .bit_cyc_in(16'h0a2c),
    .nbits_in(nbits),
    .par_en_in(par_en),
    .par_odd_in(1'b0),
    .got_out(got),
    .got_char_out(got_char),
    .got_par_ok_out(got_ok)
  );
  task automatic check(input string what, input logic [8:0] seen,
      input logic [8:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("errors %0d, checks %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  task automatic wait_q(input int lim);
    for (int n = 0; n < lim && exp_q.size() != 0; n++) begin
      @(negedge clk_sys_in);
    end
    check("pending", 9'(exp_q.size()), 9'h000);
  endtask : wait_q
  always @(posedge clk_sys_in) begin : watch
    if (got === 1'b1 && exp_q.size() != 0) begin
      check("tx_char", {got_ok, got_char}, exp_q.pop_front());
    end
  end
  always @(negedge clk_sys_in) begin : capture
    if (rx_valid_out === 1'b1) begin
      {err_seen, rx_seen} = {rx_error_out, rx_char_out};
    end
    if (resp_ready_out === 1'b1 && resp_valid_in === 1'b1) took = 1'b1;
  end
  always @(posedge clk_sys_in) begin : limit
    cyc++;
    if (cyc == 110000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin : main
    logic [7:0] c;
    int lows;
    void'($urandom(32'h024c04f0));
    {dev_addr_in, baud_sel_in, frame_sel_in} = {7'h00, 3'h6, 4'h4};
    {layout_sel_in, cycle_time_in, reg_sel_in} = {1'b1, 10'h001, 5'h09};
    {resp_valid_in, resp_char_in, nbits, par_en} = {9'h000, 4'h7, 1'b0};
    {took, lows} = {1'b0, 0};
    basic_value_in = 20'($urandom % 10001);
    for (int i = 0; i < 20; i++) begin
      reg_val[i] = 20'($urandom % 1000000);
      reg_neg[i] = (i == 9);
    end
    repeat (2) @(negedge clk_sys_in);
    sys_rst_in = 1'b0;
    foreach (addr_tab[k]) begin
      dev_addr_in = addr_tab[k];
      @(negedge clk_sys_in);
      c = {1'b0, (dev_addr_in >= 7'h0b && dev_addr_in <= 7'h63) ?
          dev_addr_in : 7'h0b};
      check("dev_addr", {2'h0, dev_addr_out}, {1'b0, c});
    end
    dev_addr_in = 7'(10 * (1 + $urandom % 9) + 1 + $urandom % 9);
    // Push of register 9, negative; first two characters only
    exp_q.push_back(9'h12d);
    exp_q.push_back({1'b1, 8'h30 + 8'(reg_val[9] / 100000)});
    wait_q(60000);
    @(negedge clk_sys_in);
    {sys_rst_in, cycle_time_in, frame_sel_in} = {1'b1, 10'h000, 4'h6};
    {nbits, par_en} = {4'h8, 1'b1};
    repeat (2) @(negedge clk_sys_in);
    sys_rst_in = 1'b0;
    {resp_valid_in, resp_char_in} = {1'b1, 8'($urandom)};
    exp_q.push_back({1'b1, resp_char_in});
    check("mode", {8'h00, mode}, 9'h000);
    c = 8'($urandom);
    host.send_char(c);
    for (int i = 0; i < 9000 && !took; i++) @(negedge clk_sys_in);
    check("mode", {8'h00, mode}, 9'h001);
    @(negedge clk_sys_in);
    resp_valid_in = 1'b0;
    check("rx_char", {err_seen, rx_seen}, {1'b0, c});
    wait_q(40000);
    check("mode", {8'h00, mode}, 9'h000);
    for (int i = 0; i < 600; i++) begin
      @(negedge clk_sys_in);
      lows += (txd_out !== 1'b1);
    end
    check("txd_low", 9'(lows), 9'h000);
    conclude();
  end
endmodule : serial_request_and_cyclic_report_bench

// File: srcr_cfg.svh
`ifndef SRCR_CFG_SVH
`define SRCR_CFG_SVH
`define SRCR_CLK_HZ 100000000
`define SRCR_SILENCE_S 20
`define SRCR_SILENCE_CYC (`SRCR_SILENCE_S * `SRCR_CLK_HZ)
`define SRCR_TICK_HZ 100
`define SRCR_TICK_CYC (`SRCR_CLK_HZ / `SRCR_TICK_HZ)
`define SRCR_ADDR_MIN 7'h0b
`define SRCR_ADDR_MAX 7'h63
`define SRCR_ADDR_RST 7'h0b
`define SRCR_BAUD_RST 3'h0
`define SRCR_FMT_RST 4'h0
`define SRCR_LAYOUT_RST 1'b0
`define SRCR_SEL_RST 5'h08
`define SRCR_SEL_MAX 5'h13
`define SRCR_CYCLE_MAX 10'h3e7
`define SRCR_CHAR_LF 8'h0a
`define SRCR_CHAR_CR 8'h0d
`define SRCR_CHAR_PLUS 8'h2b
`define SRCR_CHAR_MINUS 8'h2d
`define SRCR_CHAR_ZERO 8'h30
`endif

// File: srcr_host_model.sv
`timescale 1ns/1ps
module srcr_host_model (
  input wire logic clk_sys_in,
  input wire logic txd_in,
  output logic rxd_out,
  input wire logic [15:0] bit_cyc_in,
  input wire logic [3:0] nbits_in,
  input wire logic par_en_in,
  input wire logic par_odd_in,
  output logic got_out,
  output logic [7:0] got_char_out,
  output logic got_par_ok_out
);
  logic [7:0] d;
  logic p;
  initial begin
    {rxd_out, got_out, got_char_out, got_par_ok_out} = {2'b10, 9'h000};
  end
  task automatic bit_out(input logic v);
    rxd_out = v;
    repeat (bit_cyc_in) @(negedge clk_sys_in);
  endtask : bit_out
  task automatic send_char(input logic [7:0] c);
    logic q;
    q = par_odd_in;
    @(negedge clk_sys_in);
    bit_out(1'b0);
    for (int i = 0; i < nbits_in; i++) begin
      q = q ^ c[i];
      bit_out(c[i]);
    end
    if (par_en_in) bit_out(q);
    bit_out(1'b1);
  endtask : send_char
  always begin : rx_frames
    @(posedge clk_sys_in);
    got_out <= 1'b0;
    if (txd_in === 1'b0) begin
      repeat (bit_cyc_in / 2) @(posedge clk_sys_in);
      {d, p} = {8'h00, par_odd_in};
      for (int i = 0; i < nbits_in; i++) begin
        repeat (bit_cyc_in) @(posedge clk_sys_in);
        {d[i], p} = {txd_in, p ^ txd_in};
      end
      if (par_en_in) begin
        repeat (bit_cyc_in) @(posedge clk_sys_in);
        p = p ^ txd_in;
      end
      repeat (bit_cyc_in) @(posedge clk_sys_in);
      {got_char_out, got_par_ok_out, got_out} <=
        {d, (!par_en_in || !p) && txd_in, 1'b1};
    end
  end
endmodule : srcr_host_model

// File: srcr_pkg.sv
package srcr_pkg;
  typedef enum logic [1:0] {
    SRCR_TX_IDLE = 2'b00,
    SRCR_TX_START = 2'b01,
    SRCR_TX_BITS = 2'b10,
    SRCR_TX_STOP = 2'b11
  } srcr_tx_e;
  typedef enum logic [1:0] {
    SRCR_RX_IDLE = 2'b00,
    SRCR_RX_START = 2'b01,
    SRCR_RX_BITS = 2'b10,
    SRCR_RX_STOP = 2'b11
  } srcr_rx_e;
endpackage : srcr_pkg

// File: srcr_serial_link.sv
`timescale 1ns/1ps
`include "srcr_cfg.svh"
module srcr_serial_link #(
  parameter int unsigned SILENCE_CYC = `SRCR_SILENCE_CYC,
  parameter int unsigned TICK_CYC = `SRCR_TICK_CYC
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic rxd_in,
  output logic txd_out,
  input wire logic [6:0] dev_addr_in,
  input wire logic [2:0] baud_sel_in,
  input wire logic [3:0] frame_sel_in,
  input wire logic layout_sel_in,
  input wire logic [9:0] cycle_time_in,
  input wire logic [4:0] reg_sel_in,
  input wire logic [19:0] reg_value_in [20],
  input wire logic [19:0] basic_value_in,
  input wire logic reg_neg_in [20],
  input wire logic resp_valid_in,
  input wire logic [7:0] resp_char_in,
  output logic resp_ready_out,
  output logic [7:0] rx_char_out,
  output logic rx_valid_out,
  output logic rx_error_out,
  output logic request_response_mode_out,
  output logic [6:0] dev_addr_out
);
  // Bit period per baud code, 100 MHz clock
  logic [17:0] bitp;
  always_comb begin
    unique case (baud_sel_in)
      3'h0: bitp = 18'h028b1;
      3'h1: bitp = 18'h05161;
      3'h2: bitp = 18'h0a2c3;
      3'h3: bitp = 18'h14585;
      3'h4: bitp = 18'h28b0b;
      3'h5: bitp = 18'h01458;
      3'h6: bitp = 18'h00a2c;
      default: bitp = 18'h028b1;
    endcase
  end

  // Framing decode
  logic [3:0] nbits;
  logic par_en, par_odd, two_stop;
  always_comb begin
    nbits = (frame_sel_in < 4'h6) ? 4'h7 : 4'h8;
    par_en = (frame_sel_in < 4'h4) || (frame_sel_in == 4'h6)
             || (frame_sel_in == 4'h7);
    par_odd = (frame_sel_in == 4'h2) || (frame_sel_in == 4'h3)
              || (frame_sel_in == 4'h7);
    two_stop = (frame_sel_in < 4'h6) ? frame_sel_in[0]
               : (frame_sel_in == 4'h9);
  end

  // Address check: an out-of-range address is replaced by 0x0b
  always_comb begin
    if (dev_addr_in < `SRCR_ADDR_MIN || dev_addr_in > `SRCR_ADDR_MAX)
      dev_addr_out = `SRCR_ADDR_RST;
    else
      dev_addr_out = dev_addr_in;
  end

  // Receiver
  logic rx_s1_q, rx_s2_q;
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= rxd_in;
      rx_s2_q <= rx_s1_q;
    end
  end

  srcr_pkg::srcr_rx_e rx_st_q, rx_st_d;
  logic [17:0] rx_cnt_q, rx_cnt_d;
  logic [3:0] rx_idx_q, rx_idx_d;
  logic [8:0] rx_sh_q, rx_sh_d;
  logic [7:0] rx_char_d;
  logic rx_valid_d, rx_err_d;
  always_comb begin
    rx_st_d = rx_st_q;
    rx_cnt_d = rx_cnt_q;
    rx_idx_d = rx_idx_q;
    rx_sh_d = rx_sh_q;
    rx_char_d = rx_char_out;
    rx_valid_d = 1'b0;
    rx_err_d = rx_error_out;
    unique case (rx_st_q)
      srcr_pkg::SRCR_RX_IDLE: if (!rx_s2_q) begin
        rx_st_d = srcr_pkg::SRCR_RX_START;
        rx_cnt_d = {1'b0, bitp[17:1]};
      end
      srcr_pkg::SRCR_RX_START: begin
        if (rx_cnt_q != 18'h0) rx_cnt_d = rx_cnt_q - 18'h1;
        else if (rx_s2_q) rx_st_d = srcr_pkg::SRCR_RX_IDLE;
        else begin
          rx_st_d = srcr_pkg::SRCR_RX_BITS;
          rx_cnt_d = bitp - 18'h1;
          rx_idx_d = 4'h0;
          rx_sh_d = 9'h0;
        end
      end
      srcr_pkg::SRCR_RX_BITS: begin
        if (rx_cnt_q != 18'h0) rx_cnt_d = rx_cnt_q - 18'h1;
        else begin
          rx_sh_d[rx_idx_q] = rx_s2_q;
          rx_cnt_d = bitp - 18'h1;
          rx_idx_d = rx_idx_q + 4'h1;
          if (rx_idx_q == nbits - {3'h0, !par_en})
            rx_st_d = srcr_pkg::SRCR_RX_STOP;
        end
      end
      srcr_pkg::SRCR_RX_STOP: begin
        if (rx_cnt_q != 18'h0) rx_cnt_d = rx_cnt_q - 18'h1;
        else begin
          rx_st_d = srcr_pkg::SRCR_RX_IDLE;
          rx_valid_d = 1'b1;
          rx_char_d = (nbits == 4'h7) ? {1'b0, rx_sh_q[6:0]}
                                      : rx_sh_q[7:0];
          rx_err_d = !rx_s2_q
            || (par_en && ((^rx_sh_q[8:0] & (nbits == 4'h8))
            ^ (^rx_sh_q[7:0] & (nbits == 4'h7)) ^ par_odd));
        end
      end
      default: rx_st_d = srcr_pkg::SRCR_RX_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      rx_st_q <= srcr_pkg::SRCR_RX_IDLE;
      rx_cnt_q <= 18'h0;
      rx_idx_q <= 4'h0;
      rx_sh_q <= 9'h0;
      rx_char_out <= 8'h00;
      rx_valid_out <= 1'b0;
      rx_error_out <= 1'b0;
    end else begin
      rx_st_q <= rx_st_d;
      rx_cnt_q <= rx_cnt_d;
      rx_idx_q <= rx_idx_d;
      rx_sh_q <= rx_sh_d;
      rx_char_out <= rx_char_d;
      rx_valid_out <= rx_valid_d;
      rx_error_out <= rx_err_d;
    end
  end

  // Mode, silence and cycle timers
  logic [31:0] sil_q, sil_d;
  logic [23:0] tick_q, tick_d;
  logic [9:0] cyc_q, cyc_d;
  logic mode_d, push_go;
  always_comb begin
    sil_d = sil_q;
    mode_d = request_response_mode_out;
    tick_d = tick_q + 24'h1;
    cyc_d = cyc_q;
    push_go = 1'b0;
    if (rx_valid_out) begin
      sil_d = 32'h0;
      mode_d = 1'b1;
    end else if (request_response_mode_out) begin
      if (sil_q >= SILENCE_CYC - 1) mode_d = 1'b0;
      else sil_d = sil_q + 32'h1;
    end
    if (tick_q >= 24'(TICK_CYC - 1)) begin
      tick_d = 24'h0;
      if (cycle_time_in == 10'h0 || request_response_mode_out)
        cyc_d = 10'h0;
      else if (cyc_q >= cycle_time_in - 10'h1) begin
        cyc_d = 10'h0;
        push_go = 1'b1;
      end else cyc_d = cyc_q + 10'h1;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      sil_q <= 32'h0;
      tick_q <= 24'h0;
      cyc_q <= 10'h0;
      request_response_mode_out <= 1'b0;
    end else begin
      sil_q <= sil_d;
      tick_q <= tick_d;
      cyc_q <= cyc_d;
      request_response_mode_out <= mode_d;
    end
  end

  // Push message: [addr2] sign d6 LF CR
  logic [19:0] val;
  logic neg;
  always_comb begin
    if (reg_sel_in > `SRCR_SEL_MAX || reg_sel_in == 5'h08) begin
      val = basic_value_in;
      neg = 1'b0;
    end else begin
      val = reg_value_in[reg_sel_in];
      neg = reg_neg_in[reg_sel_in];
    end
  end
  logic [7:0] msg_q [11];
  logic [7:0] msg_d [11];
  logic [3:0] mpos_q, mpos_d, mlen_q, mlen_d;
  logic busy_q, busy_d, tx_take;
  logic [19:0] rem;
  always_comb begin
    msg_d = msg_q;
    mpos_d = mpos_q;
    mlen_d = mlen_q;
    busy_d = busy_q;
    rem = val;
    if (busy_q && tx_take) begin
      mpos_d = mpos_q + 4'h1;
      if (mpos_q == mlen_q - 4'h1) busy_d = 1'b0;
    end else if (!busy_q && push_go) begin
      msg_d[0] = `SRCR_CHAR_ZERO + 8'(dev_addr_out / 7'd10);
      msg_d[1] = `SRCR_CHAR_ZERO + 8'(dev_addr_out % 7'd10);
      msg_d[2] = neg ? `SRCR_CHAR_MINUS : `SRCR_CHAR_PLUS;
      for (int i = 8; i >= 3; i--) begin
        msg_d[i] = `SRCR_CHAR_ZERO + 8'(rem % 20'd10);
        rem = rem / 20'd10;
      end
      msg_d[9] = `SRCR_CHAR_LF;
      msg_d[10] = `SRCR_CHAR_CR;
      mpos_d = layout_sel_in ? 4'h2 : 4'h0;
      mlen_d = 4'hb;
      busy_d = 1'b1;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < 11; i++) msg_q[i] <= 8'h00;
      mpos_q <= 4'h0;
      mlen_q <= 4'h0;
      busy_q <= 1'b0;
    end else begin
      msg_q <= msg_d;
      mpos_q <= mpos_d;
      mlen_q <= mlen_d;
      busy_q <= busy_d;
    end
  end

  // Transmitter: a pending push message has priority over a response in either mode
  logic tx_req;
  logic [7:0] tx_char;
  always_comb begin
    tx_req = busy_q || (request_response_mode_out && resp_valid_in);
    tx_char = busy_q ? msg_q[mpos_q] : resp_char_in;
  end
  srcr_pkg::srcr_tx_e tx_st_q, tx_st_d;
  logic [17:0] tx_cnt_q, tx_cnt_d;
  logic [3:0] tx_idx_q, tx_idx_d;
  logic [10:0] tx_sh_q, tx_sh_d;
  logic txd_d;
  always_comb begin
    tx_st_d = tx_st_q;
    tx_cnt_d = tx_cnt_q;
    tx_idx_d = tx_idx_q;
    tx_sh_d = tx_sh_q;
    txd_d = txd_out;
    tx_take = 1'b0;
    unique case (tx_st_q)
      srcr_pkg::SRCR_TX_IDLE: begin
        txd_d = 1'b1;
        if (tx_req) begin
          tx_take = 1'b1;
          tx_sh_d = 11'h7ff;
          if (nbits == 4'h7)
            tx_sh_d[7:0] = {par_en ? (^tx_char[6:0] ^ par_odd) : 1'b1,
                            tx_char[6:0]};
          else
            tx_sh_d[8:0] = {par_en ? (^tx_char ^ par_odd) : 1'b1,
                            tx_char};
          tx_idx_d = nbits + {3'h0, par_en} + {3'h0, two_stop};
          tx_cnt_d = bitp - 18'h1;
          txd_d = 1'b0;
          tx_st_d = srcr_pkg::SRCR_TX_BITS;
        end
      end
      srcr_pkg::SRCR_TX_BITS: begin
        if (tx_cnt_q != 18'h0) tx_cnt_d = tx_cnt_q - 18'h1;
        else begin
          txd_d = tx_sh_q[0];
          tx_sh_d = {1'b1, tx_sh_q[10:1]};
          tx_cnt_d = bitp - 18'h1;
          if (tx_idx_q == 4'h0) tx_st_d = srcr_pkg::SRCR_TX_STOP;
          else tx_idx_d = tx_idx_q - 4'h1;
        end
      end
      srcr_pkg::SRCR_TX_STOP: begin
        if (tx_cnt_q != 18'h0) tx_cnt_d = tx_cnt_q - 18'h1;
        else tx_st_d = srcr_pkg::SRCR_TX_IDLE;
      end
      default: tx_st_d = srcr_pkg::SRCR_TX_IDLE;
    endcase
  end
  always_comb resp_ready_out = tx_take && !busy_q;
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      tx_st_q <= srcr_pkg::SRCR_TX_IDLE;
      tx_cnt_q <= 18'h0;
      tx_idx_q <= 4'h0;
      tx_sh_q <= 11'h7ff;
      txd_out <= 1'b1;
    end else begin
      tx_st_q <= tx_st_d;
      tx_cnt_q <= tx_cnt_d;
      tx_idx_q <= tx_idx_d;
      tx_sh_q <= tx_sh_d;
      txd_out <= txd_d;
    end
  end
endmodule : srcr_serial_link

// File: srcr_serial_link_properties.sv
`timescale 1ns/1ps
module srcr_serial_link_properties #(
  parameter int unsigned SILENCE_CYC = 2000
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic txd_out,
  input wire logic [6:0] dev_addr_in,
  input wire logic resp_valid_in,
  input wire logic resp_ready_out,
  input wire logic rx_valid_out,
  input wire logic request_response_mode_out,
  input wire logic [6:0] dev_addr_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (sys_rst_in);
  wire logic mode;
  logic [31:0] quiet_q;
  logic [31:0] quiet_d;
  assign mode = request_response_mode_out;
  // Cycles since the last received character
  always_comb begin
    quiet_d = rx_valid_out ? 32'h0 : quiet_q + 32'h1;
  end
  always_ff @(posedge clk_sys_in) begin
    quiet_q <= sys_rst_in ? 32'h0 : quiet_d;
  end
  a_reset_idle: assert property (disable iff (1'b0)
    sys_rst_in |=> txd_out && !mode) else $error("not idle after reset");
  a_rx_to_mode: assert property (
    rx_valid_out |=> mode [*8]) else $error("no mode change on char");
  a_mode_cause: assert property (
    $rose(mode) |-> $past(rx_valid_out)) else $error("mode rose alone");
  a_silence_exit: assert property (
    quiet_q == SILENCE_CYC + 4 |-> !mode) else $error("silence ignored");
  a_addr_legal: assert property (
    dev_addr_out == ((dev_addr_in >= 7'h0b && dev_addr_in <= 7'h63) ?
    dev_addr_in : 7'h0b)) else $error("bad address");
  a_push_refuse: assert property (
    !mode |-> !resp_ready_out) else $error("answer taken in push mode");
  a_ready_cause: assert property (
    resp_ready_out |-> resp_valid_in && txd_out) else $error("bad ready");
  a_answer_start: assert property (
    resp_ready_out |=> !txd_out [*8]) else $error("no start bit");
  a_rx_pulse: assert property (
    rx_valid_out |=> !rx_valid_out) else $error("rx pulse too long");
  c_rx_char: cover property (rx_valid_out);
  c_answer: cover property (resp_ready_out);
  c_back_push: cover property ($fell(mode));
endmodule : srcr_serial_link_properties

bind srcr_serial_link srcr_serial_link_properties #(
  .SILENCE_CYC(SILENCE_CYC)
) u_props (
  .clk_sys_in(clk_sys_in),
  .sys_rst_in(sys_rst_in),
  .txd_out(txd_out),
  .dev_addr_in(dev_addr_in),
  .resp_valid_in(resp_valid_in),
  .resp_ready_out(resp_ready_out),
  .rx_valid_out(rx_valid_out),
  .request_response_mode_out(request_response_mode_out),
  .dev_addr_out(dev_addr_out)
);
